// [ref_dac_pkg.sv]
package ref_dac_pkg;

	// ------------------------------------------------------------
	// Register offsets and widths
	// ------------------------------------------------------------
	localparam int          ADDR_W           = 4;
	localparam int          DATA_W           = 8;
	localparam logic [3:0]  OFS_REF_CTRL     = 4'h0;
	localparam logic [3:0]  OFS_SRC_CTRL     = 4'h1;
	localparam logic [3:0]  OFS_LEVEL        = 4'h2;
	localparam logic [3:0]  OFS_STATUS       = 4'h3;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int          POS_REF_EN       = 7;
	localparam int          POS_REF_RDY      = 6;
	localparam int          POS_GAIN         = 4;
	localparam int          POS_LAD_EN       = 7;
	localparam int          POS_LPS          = 6;
	localparam int          POS_AOE          = 5;
	localparam int          POS_PSS          = 2;
	localparam int          POS_NSS          = 0;
	localparam int          POS_CONV_FIXED   = 0;
	localparam int          LEVEL_W          = 5;

	// ------------------------------------------------------------
	// Reset values and encodings
	// ------------------------------------------------------------
	localparam logic [1:0]  GAIN_OFF         = 2'h0;
	localparam logic [1:0]  GAIN_X1          = 2'h1;
	localparam logic [1:0]  GAIN_X2          = 2'h2;
	localparam logic [1:0]  GAIN_X4          = 2'h3;
	localparam logic [1:0]  PSS_SUPPLY       = 2'h0;
	localparam logic [1:0]  PSS_EXT_PIN      = 2'h1;
	localparam logic [1:0]  PSS_FIXED        = 2'h2;
	localparam logic [1:0]  PSS_RESERVED     = 2'h3;
	localparam logic [1:0]  RST_GAIN         = 2'h1;
	localparam logic [4:0]  RST_LEVEL        = 5'h00;

	// ------------------------------------------------------------
	// Timing: stabilisation wait
	// ------------------------------------------------------------
	localparam int          CLK_MHZ          = 100;
	localparam int          SETTLE_US        = 25;
	localparam int          SETTLE_CYCLES    = SETTLE_US * CLK_MHZ;
	localparam int          SETTLE_W         = 16;

endpackage

// [settle_timer.sv]
`timescale 1ns/1ns
module settle_timer
	import ref_dac_pkg::*;
#(
	parameter int  CYCLES = SETTLE_CYCLES
) (
	input  wire logic  clk,
	input  wire logic  rst,
	input  wire logic  ce,
	input  wire logic  enable,
	input  wire logic  stable_sync,
	input  wire logic  use_stable_in,
	output logic       ready
);

	typedef struct packed {
		logic [SETTLE_W-1:0]  count;
		logic                 ready;
	} timer_state_t;

	timer_state_t  state;
	timer_state_t  next_state;

	localparam logic [SETTLE_W-1:0] LAST = SETTLE_W'(CYCLES - 1);

	// Count from enable; disable clears at once
	always_comb begin
		next_state = state;
		if (!enable) begin
			next_state.count = '0; // R19
			next_state.ready = 1'b0; // R2
		end else if (use_stable_in) begin
			next_state.ready = stable_sync; // R19
		end else if (state.count >= LAST) begin
			next_state.ready = 1'b1; // R2
		end else begin
			next_state.count = state.count + 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= '0;
		end else if (ce) begin
			state <= next_state;
		end
	end

	assign ready = state.ready;

endmodule // settle_timer

// [ref_dac_ctrl.sv]
// Functional notes
// R1: Reference enable bit powers the fixed reference; clear keeps it off.
// R2: Ready flag sets only after stabilisation; reads zero when off or unsettled.
// R3: Gain select 00 off, 01 unity, 10 double, 11 quadruple.
// R4: Converter buffer on only while converter uses the fixed reference.
// R5: Reference control bits 3-2 reserved, read zero, written zero.
// R6: Ladder enabled while its enable bit set, disabled when clear.
// R7: Five-bit level code picks one of 32 ladder taps.
// R8: Low-power select set cuts negative source, clear cuts positive.
// R9: Software clamps to positive source with all-ones code, ladder off.
// R10: Software clamps to negative source with all-zeros code, ladder off.
// R11: Output enable routes ladder to pin, overriding digital driver and detector.
// R12: Digital read of pin returns zero while pin carries the ladder.
// R13: Positive source 00 supply, 01 external pin, 10 fixed; 11 reserved.
// R14: Negative source select: set external pin, clear ground.
// R15: Wake from sleep leaves source control register unchanged.
// R16: Reset disables ladder, frees pin, clears level code.
// R17: Unimplemented bits ignore writes and read zero.
// R18: Software should disable reference before sleep.
// R19: Ready from synchronised stable input or counter; clears on disable.
// R20: Registers reached over simple synchronous port with one-cycle strobes.
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
module ref_dac_ctrl
	import ref_dac_pkg::*;
#(
	parameter int  SETTLE = SETTLE_CYCLES
) (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  ce,
	input  wire logic [ADDR_W-1:0]     addr,
	input  wire logic [DATA_W-1:0]     wdata,
	input  wire logic                  wr,
	input  wire logic                  rd,
	output logic      [DATA_W-1:0]     rdata,
	input  wire logic                  stable_in,
	input  wire logic                  pin_digital_in,
	input  wire logic                  pin_digital_out,
	input  wire logic                  pin_digital_oe,
	input  wire logic                  converter_uses_fixed,
	input  wire logic                  sleep_wake,
	output logic                       reference_enable,
	output logic      [1:0]            reference_gain_select,
	output logic                       converter_reference_buffer,
	output logic                       ladder_enable,
	output logic                       positive_source_connect,
	output logic                       negative_source_connect,
	output logic      [1:0]            positive_source_select,
	output logic                       negative_source_select,
	output logic      [LEVEL_W-1:0]    ladder_level_code,
	output logic                       analog_output_enable,
	output logic                       pin_read_value,
	output logic                       pin_drive_out,
	output logic                       pin_drive_oe,
	output logic                       reference_ready_flag
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic                ref_en;
		logic [1:0]          gain;
		logic                lad_en;
		logic                lps;
		logic                aoe;
		logic [1:0]          pss;
		logic                nss;
		logic [LEVEL_W-1:0]  level;
		logic                use_stable;
		logic [DATA_W-1:0]   rdata;
		logic [1:0]          stable_meta;
		logic                stable_sync;
		logic [1:0]          conv_meta;
		logic                conv_sync;
		logic [1:0]          pin_meta;
		logic                pin_sync;
		logic                conv_buf;
		logic                lad_out;
		logic                pos_conn;
		logic                neg_conn;
		logic                pin_rd;
		logic                pin_out;
		logic                pin_oe;
		logic                ready;
	} ctrl_state_t;

	ctrl_state_t  state;
	ctrl_state_t  next_state;
	logic         timer_ready;

	// ------------------------------------------------------------
	// Stabilisation timer
	// ------------------------------------------------------------
	settle_timer #(
		.CYCLES        (SETTLE)
	) u_settle (
		.clk           (clk),
		.rst           (rst),
		.ce            (ce),
		.enable        (state.ref_en),
		.stable_sync   (state.stable_sync),
		.use_stable_in (state.use_stable),
		.ready         (timer_ready)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;

		// Three-flop synchronisers for pin-side levels
		next_state.stable_meta = {state.stable_meta[0], stable_in};
		next_state.stable_sync = state.stable_meta[1];
		next_state.conv_meta   = {state.conv_meta[0], converter_uses_fixed};
		next_state.conv_sync   = state.conv_meta[1];
		next_state.pin_meta    = {state.pin_meta[0], pin_digital_in};
		next_state.pin_sync    = state.pin_meta[1];

		// Register writes; sleep wake has no path here, so contents hold
		if (wr) begin // R20
			unique case (addr)
				OFS_REF_CTRL: begin
					next_state.ref_en = wdata[POS_REF_EN]; // R1
					next_state.gain   = wdata[POS_GAIN +: 2]; // R3
				end
				OFS_SRC_CTRL: begin
					next_state.lad_en = wdata[POS_LAD_EN]; // R6
					next_state.lps    = wdata[POS_LPS]; // R8
					next_state.aoe    = wdata[POS_AOE]; // R11
					next_state.pss    = wdata[POS_PSS +: 2]; // R13
					next_state.nss    = wdata[POS_NSS]; // R14
				end
				OFS_LEVEL: begin
					next_state.level = wdata[LEVEL_W-1:0]; // R7
				end
				OFS_STATUS: begin
					next_state.use_stable = wdata[POS_CONV_FIXED]; // R19
				end
				default: begin
				end
			endcase
		end

		// Read data valid only in the cycle after the strobe
		next_state.rdata = '0;
		if (rd) begin
			unique case (addr)
				OFS_REF_CTRL: begin
					next_state.rdata[POS_REF_EN]    = state.ref_en;
					next_state.rdata[POS_REF_RDY]   = state.ready; // R2
					next_state.rdata[POS_GAIN +: 2] = state.gain; // R5
				end
				OFS_SRC_CTRL: begin
					next_state.rdata[POS_LAD_EN]   = state.lad_en;
					next_state.rdata[POS_LPS]      = state.lps;
					next_state.rdata[POS_AOE]      = state.aoe;
					next_state.rdata[POS_PSS +: 2] = state.pss;
					next_state.rdata[POS_NSS]      = state.nss; // R17
				end
				OFS_LEVEL: begin
					next_state.rdata[LEVEL_W-1:0] = state.level; // R17
				end
				OFS_STATUS: begin
					next_state.rdata[POS_CONV_FIXED] = state.use_stable;
				end
				default: begin
				end
			endcase
		end

		// Analog steering
		next_state.conv_buf = state.ref_en && state.conv_sync; // R4
		next_state.lad_out  = state.lad_en; // R6
		next_state.neg_conn = !state.lps || state.lad_en; // R8
		next_state.pos_conn = state.lps || state.lad_en; // R8

		// Pin override follows the new enable, so pin and enable switch on one edge
		next_state.pin_rd  = next_state.aoe ? 1'b0 : state.pin_sync; // R12
		next_state.pin_out = next_state.aoe ? 1'b0 : pin_digital_out; // R11
		next_state.pin_oe  = next_state.aoe ? 1'b0 : pin_digital_oe; // R11

		// Ready is dropped the moment enable goes low
		next_state.ready = timer_ready && state.ref_en && next_state.ref_en; // R19
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			state       <= '0; // R16
			state.gain  <= RST_GAIN;
			state.level <= RST_LEVEL; // R16
		end else if (ce) begin
			state <= next_state; // R15
		end
	end

	// ------------------------------------------------------------
	// Outputs, all from flops
	// ------------------------------------------------------------
	assign rdata                      = state.rdata;
	assign reference_enable           = state.ref_en; // R1
	assign reference_gain_select      = state.gain; // R3
	assign converter_reference_buffer = state.conv_buf; // R4
	assign ladder_enable              = state.lad_out; // R6
	assign positive_source_connect    = state.pos_conn;
	assign negative_source_connect    = state.neg_conn;
	assign positive_source_select     = state.pss; // R13
	assign negative_source_select     = state.nss; // R14
	assign ladder_level_code          = state.level; // R7
	assign analog_output_enable       = state.aoe; // R11
	assign pin_read_value             = state.pin_rd; // R12
	assign pin_drive_out              = state.pin_out;
	assign pin_drive_oe               = state.pin_oe;
	assign reference_ready_flag       = state.ready; // R2

endmodule // ref_dac_ctrl

// [ref_dac_props.sv]
`timescale 1ns/1ns
module ref_dac_props
	import ref_dac_pkg::*;
(
	input wire logic               clk,
	input wire logic               rst,
	input wire logic [ADDR_W-1:0]  addr,
	input wire logic [DATA_W-1:0]  wdata,
	input wire logic               wr,
	input wire logic               rd,
	input wire logic [DATA_W-1:0]  rdata,
	input wire logic               converter_uses_fixed,
	input wire logic               converter_reference_buffer,
	input wire logic               ladder_enable,
	input wire logic [LEVEL_W-1:0] ladder_level_code,
	input wire logic               analog_output_enable,
	input wire logic               pin_read_value,
	input wire logic               pin_drive_oe,
	input wire logic               reference_ready_flag
);
	// ----------------------------------------
	// Port relations, one clock domain
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Read data only lives in the cycle after a read strobe
	a_rdata_idle:
		assert property (!$past(rd) |-> rdata == 8'h00) else $error("read data not idle");
	a_ref_spare:
		assert property ($past(rd) && $past(addr) == OFS_REF_CTRL |-> rdata[3:0] == 4'h0)
		else $error("reference control low bits not zero");
	a_level_upper:
		assert property ($past(rd) && $past(addr) == OFS_LEVEL |-> rdata[7:5] == 3'h0)
		else $error("level upper bits not zero");
	a_src_gaps:
		assert property ($past(rd) && $past(addr) == OFS_SRC_CTRL |-> !rdata[4] && !rdata[1])
		else $error("source control gaps not zero");
	// Ladder enable passes one output stage; level and output enable show the register
	a_ladder_follow:
		assert property (wr && addr == OFS_SRC_CTRL
			|-> ##2 ladder_enable == $past(wdata[POS_LAD_EN], 2)) else $error("ladder enable lag");
	a_level_follow:
		assert property (wr && addr == OFS_LEVEL
			|-> ##1 ladder_level_code == $past(wdata[4:0])) else $error("level code lag");
	a_aoe_follow:
		assert property (wr && addr == OFS_SRC_CTRL
			|-> ##1 analog_output_enable == $past(wdata[POS_AOE])) else $error("output enable lag");
	a_pin_quiet:
		assert property (analog_output_enable
			|-> !pin_read_value && !pin_drive_oe) else $error("pin not overridden");
	// Synchroniser depth is hidden, so only the settled low case is pinned
	a_buffer_off:
		assert property (!converter_uses_fixed [*6] |-> !converter_reference_buffer)
		else $error("converter buffer on without fixed reference");
	a_ready_drop:
		assert property (wr && addr == OFS_REF_CTRL && !wdata[POS_REF_EN]
			|-> ##1 !reference_ready_flag [*2]) else $error("ready not cleared");
	a_reset_clear:
		assert property (disable iff (1'b0) $fell(rst)
			|-> !ladder_enable && ladder_level_code == 5'h00 && !analog_output_enable)
		else $error("reset left ladder active");
endmodule // ref_dac_props

bind ref_dac_ctrl ref_dac_props u_props (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .rdata(rdata), .converter_uses_fixed(converter_uses_fixed),
	.converter_reference_buffer(converter_reference_buffer), .ladder_enable(ladder_enable),
	.ladder_level_code(ladder_level_code), .analog_output_enable(analog_output_enable),
	.pin_read_value(pin_read_value), .pin_drive_oe(pin_drive_oe),
	.reference_ready_flag(reference_ready_flag));

// [test_voltage_reference_dac_control.sv]
`timescale 1ns/1ns
module test_voltage_reference_dac_control;
	import ref_dac_pkg::*;
	localparam int SET = 4;
	logic        clk;
	logic        rst = 1'b1;
	logic        wr = 1'b0, rd = 1'b0, stb = 1'b0, pin = 1'b0, dout = 1'b0, doe = 1'b0;
	logic        cuf = 1'b0, wake = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [7:0]  wdata = 8'h00, rdata;
	logic [7:0]  r [3];
	logic [31:0] seed = 32'ha317, v;
	logic [1:0]  gain, pss;
	logic [4:0]  lvl;
	logic        ren, bon, len, pcon, ncon, nss, aoe, prd, pout, poe, rdy;
	int          fails = 0, checks_done = 0, n;

	// Short settle count keeps the ready wait to a few cycles
	ref_dac_ctrl #(.SETTLE(SET)) DUT (
		.clk(clk), .rst(rst), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .stable_in(stb), .pin_digital_in(pin), .pin_digital_out(dout),
		.pin_digital_oe(doe), .converter_uses_fixed(cuf), .sleep_wake(wake),
		.reference_enable(ren), .reference_gain_select(gain), .converter_reference_buffer(bon),
		.ladder_enable(len), .positive_source_connect(pcon), .negative_source_connect(ncon),
		.positive_source_select(pss), .negative_source_select(nss), .ladder_level_code(lvl),
		.analog_output_enable(aoe), .pin_read_value(prd), .pin_drive_out(pout),
		.pin_drive_oe(poe), .reference_ready_flag(rdy));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Readable bits; ready is added apart, it moves on its own
	function automatic logic [7:0] rd_mask(input logic [3:0] a);
		case (a)
			OFS_REF_CTRL: return 8'hb0;
			OFS_SRC_CTRL: return 8'hed;
			OFS_LEVEL:    return 8'h1f;
			default:      return 8'h00;
		endcase
	endfunction
	// Off ladder keeps one end: low-power set keeps the positive end
	function automatic logic [7:0] exp_ctrl(input logic [7:0] a, input logic [7:0] b);
		return {a[7], a[5:4], b[7], b[5], b[0], b[7] | b[6], b[7] | !b[6]};
	endfunction
	// Buffer needs the reference on as well as the converter request
	function automatic logic [7:0] exp_pin(input logic [7:0] b, input logic p, o, c, d);
		return {b[5] ? 2'b00 : {p, o}, c, !b[5] && d, 4'h0};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		checks_done++;
		if (got !== exp) begin
			$display("[ERR] %0t %s", $time, m);
			fails++;
		end
	endtask
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata & m, e, "read back");
	endtask
	task automatic wait_rdy();
		n = 0;
		#1;
		while (rdy !== 1'b1 && n < 40) begin
			@(posedge clk);
			#1 n++;
		end
		if (n >= 40) begin
			$display("[ERR] %0t ready timeout", $time);
			fails++;
			print_verdict();
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rchk(OFS_REF_CTRL, 8'hff, 8'h10);
		rchk(OFS_SRC_CTRL, 8'hff, 8'h00);
		rchk(OFS_LEVEL, 8'hff, 8'h00);
		rchk(4'h9, 8'hff, 8'h00);
		$display("test reset done");
		// Every gain and legal source code, random other fields
		for (int i = 0; i < 24; i++) begin
			v = rnd();
			r[0] = {v[7:6], i[1:0], 2'b00, v[1:0]};
			r[1] = {v[15:12], 2'(i % 3), v[9:8]};
			r[2] = v[23:16];
			@(posedge clk);
			{cuf, pin, doe, dout, stb, wake} <= v[29:24];
			for (int k = 0; k < 3; k++) wreg(4'(k), r[k]);
			repeat (8) @(posedge clk);
			#1 chk({ren, gain, len, aoe, nss, pcon, ncon}, exp_ctrl(r[0], r[1]), "ctrl");
			chk({pss, lvl, 1'b0}, {r[1][3:2], r[2][4:0], 1'b0}, "source");
			chk({prd, poe, bon, pout, 4'h0}, exp_pin(r[1], pin, doe, cuf && r[0][7], dout), "pin");
			for (int k = 0; k < 3; k++) rchk(4'(k), 8'hff, (r[k] & rd_mask(4'(k))) | {1'b0, k == 0 && r[0][7], 6'h00});
		end
		$display("test random done");
		wreg(OFS_REF_CTRL, 8'h00);
		wreg(OFS_STATUS, 8'h00);
		wreg(OFS_REF_CTRL, 8'h90);
		wait_rdy();
		chk(8'(n >= SET && n <= SET + 3), 8'h01, "ready timing");
		rchk(OFS_REF_CTRL, 8'hff, 8'hd0);
		wreg(OFS_REF_CTRL, 8'h10);
		#1 chk({7'h00, rdy}, 8'h00, "ready drop");
		@(posedge clk);
		stb <= 1'b0;
		wreg(OFS_STATUS, 8'h01);
		wreg(OFS_REF_CTRL, 8'h90);
		repeat (10) @(posedge clk);
		#1 chk({7'h00, rdy}, 8'h00, "ready early");
		@(posedge clk);
		stb <= 1'b1;
		wait_rdy();
		chk(8'(n < 8), 8'h01, "ready stable");
		$display("test ready done");
		// Clamp to positive end, then wake and a mid-run reset
		wreg(OFS_SRC_CTRL, 8'h48);
		wreg(OFS_LEVEL, 8'h1f);
		wreg(OFS_REF_CTRL, 8'h10);
		@(posedge clk);
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		repeat (4) @(posedge clk);
		#1 chk({len, pcon, ncon, lvl}, {3'b010, 5'h1f}, "clamp");
		rchk(OFS_SRC_CTRL, 8'hff, 8'h48);
		wreg(OFS_SRC_CTRL, 8'he8);
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		#1 chk({len, aoe, lvl, 1'b0}, 8'h00, "reset");
		rchk(OFS_LEVEL, 8'hff, 8'h00);
		// Clamp to the negative end after reset
		wreg(OFS_SRC_CTRL, 8'h01);
		wreg(OFS_LEVEL, 8'h00);
		repeat (2) @(posedge clk);
		#1 chk({len, pcon, ncon, lvl}, {3'b001, 5'h00}, "clamp low");
		$display("test sleep reset done");
		print_verdict();
	end
endmodule // test_voltage_reference_dac_control
